/* core/pdfs_supervisor.sv */
// Purpose: fault supervision and enable logic for a two half-bridge piezo driver with buck
// Assumes: comparator and sensor inputs are synchronous, active high when tripped
// Notes: fault_out_n is open drain; oe low means pin pulled low
// Function
// - buck target picked by two-state pin: nominal or raised headroom rail
// - buck high side on while feedback below reference, off when above
// - buck high side forced off whenever switch current exceeds limit
// - buck undervoltage disables buck switches, pulls fault low, self-recovers
// - buck overcurrent only after current stays high past deglitch interval
// - buck overcurrent disables buck, pulls fault low, retries after interval
// - charge pump off while sleep/reset input is low
// - four-level edge-speed pin selects one of four slew settings
// - each half-bridge waits for opposite gate off before switching on
// - PWM inputs pass a deglitch filter adding small delay
// - main supply undervoltage disables bridge, pump, controller; recovers after
// - logic rail undervoltage disables bridge, pumps, controller; recovers after
// - pump rail undervoltage disables bridge, pulls fault low; self-recovers
// - bridge overcurrent past deglitch time enters latched shutdown
// - latched shutdown holds bridge off, fault low until reset pulse
// - bridge overcurrent threshold chosen by two-state level pin
// - two die temperature sensors monitored, each can shut down
// - switch-area thermal trip shuts bridge, pump and buck off (controller stays on), fault low, self-recovers
// - general die thermal trip shuts bridge, pump and buck off (controller stays on), fault low, self-recovers
// - fault output open drain active low with external pull-up
`timescale 1ns/1ns
`default_nettype none
`include "pdfs_regs.svh"
module pdfs_supervisor
    import pdfs_pkg::*;
#(
    parameter int BUCK_DEG_CYC = `PDFS_BUCK_OCP_DEG_CYC,
    parameter int BRIDGE_DEG_CYC = `PDFS_BRIDGE_OCP_DEG_CYC,
    parameter int BUCK_RETRY_CYC = `PDFS_BUCK_RETRY_CYC,
    parameter int RST_WINDOW_CYC = `PDFS_RST_WINDOW_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // controller pins
    input wire logic sleep_reset_n_i,
    input wire logic pwm_a_i,
    input wire logic pwm_b_i,
    // configuration pins
    input wire logic buck_level_pin_i,
    input wire logic overcurrent_level_pin_i,
    input wire logic [1:0] edge_speed_pin_i,
    // supply and sensor comparators
    input wire logic supply_low_lockout_i,
    input wire logic logic_rail_low_i,
    input wire logic pump_undervoltage_i,
    input wire logic buck_feedback_low_i,
    input wire logic buck_feedback_below_ref_i,
    input wire logic buck_current_limit_i,
    input wire logic buck_current_ocp_i,
    input wire logic bridge_current_high_lo_i,
    input wire logic bridge_current_high_hi_i,
    input wire logic thermal_shutdown_fet_i,
    input wire logic thermal_shutdown_die_i,
    // gate feedback
    input wire logic [1:0] hs_gate_low_i,
    input wire logic [1:0] ls_gate_low_i,
    // bridge and buck drive
    output logic [1:0] hs_on_o,
    output logic [1:0] ls_on_o,
    output logic buck_hs_on_o,
    output logic buck_sw_en_o,
    output logic buck_sel_o,
    output logic pump_en_o,
    output logic controller_en_o,
    output logic [1:0] slew_sel_o,
    output logic overcurrent_hi_o,
    // fault pin, open drain
    output logic fault_out_n_o,
    output logic fault_out_n_oe_o
);
    localparam int CW = 16;
    typedef struct packed {
        logic [CW-1:0] bk_deg;
        logic [CW-1:0] br_deg;
        logic [CW-1:0] retry;
        logic [CW-1:0] low_cnt;
        pdfs_buck_e bk;
        logic ocp_latch;
        logic rst_prev;
        logic sleep;
        logic buck_hs;
        logic buck_en;
        logic buck_sel;
        logic pump;
        logic ctrl;
        logic [1:0] slew;
        logic oc_hi;
        logic fault_oe;
        logic bridge_en;
    } pdfs_sup_s;
    pdfs_sup_s st_q, st_d;
    logic br_oc;
    logic sig_fault;
    logic [1:0] hs_w, ls_w;
    logic [1:0] hs_q, ls_q;
    assign br_oc = st_q.oc_hi ? bridge_current_high_hi_i : bridge_current_high_lo_i;
    assign sig_fault = buck_feedback_low_i || (st_q.bk == PDFS_BK_RETRY) ||
        pump_undervoltage_i || st_q.ocp_latch ||
        thermal_shutdown_fet_i || thermal_shutdown_die_i;
    always_comb begin
        st_d = st_q;
        st_d.rst_prev = sleep_reset_n_i;
        st_d.buck_sel = buck_level_pin_i ? `PDFS_BUCK_SEL_HIGH : `PDFS_BUCK_SEL_LOW;
        st_d.slew = edge_speed_pin_i;
        st_d.oc_hi = overcurrent_level_pin_i;
        // reset pulse and sleep timing
        if (!sleep_reset_n_i) begin
            if (st_q.low_cnt < CW'(RST_WINDOW_CYC)) begin
                st_d.low_cnt = st_q.low_cnt + 1'b1;
            end else begin
                st_d.sleep = 1'b1;
            end
        end else begin
            st_d.low_cnt = '0;
            st_d.sleep = 1'b0;
            if (!st_q.rst_prev && !st_q.sleep) begin
                st_d.ocp_latch = 1'b0;
            end
        end
        // bridge overcurrent deglitch and latch
        if (br_oc) begin
            if (st_q.br_deg >= CW'(BRIDGE_DEG_CYC)) begin
                st_d.ocp_latch = 1'b1;
            end else begin
                st_d.br_deg = st_q.br_deg + 1'b1;
            end
        end else begin
            st_d.br_deg = '0;
        end
        // buck overcurrent deglitch and retry
        case (st_q.bk)
            PDFS_BK_RUN: begin
                if (buck_current_ocp_i) begin
                    if (st_q.bk_deg >= CW'(BUCK_DEG_CYC)) begin
                        st_d.bk = PDFS_BK_RETRY;
                        st_d.bk_deg = '0;
                        st_d.retry = '0;
                    end else begin
                        st_d.bk_deg = st_q.bk_deg + 1'b1;
                    end
                end else begin
                    st_d.bk_deg = '0;
                end
            end
            PDFS_BK_RETRY: begin
                if (st_q.retry >= CW'(BUCK_RETRY_CYC - 1)) begin
                    st_d.bk = PDFS_BK_RUN;
                end else begin
                    st_d.retry = st_q.retry + 1'b1;
                end
            end
            default: st_d.bk = PDFS_BK_RUN;
        endcase
        st_d.ctrl = !supply_low_lockout_i && !logic_rail_low_i && sleep_reset_n_i;
        st_d.pump = st_d.ctrl && !thermal_shutdown_fet_i && !thermal_shutdown_die_i;
        st_d.bridge_en = st_d.pump && !pump_undervoltage_i && !st_d.ocp_latch && !br_oc;
        st_d.buck_en = !buck_feedback_low_i && (st_d.bk == PDFS_BK_RUN) &&
            !thermal_shutdown_fet_i && !thermal_shutdown_die_i;
        st_d.buck_hs = st_d.buck_en && buck_feedback_below_ref_i && !buck_current_limit_i;
        st_d.fault_oe = !(sig_fault || (st_d.bk == PDFS_BK_RETRY) || st_d.ocp_latch);
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
            st_q.rst_prev <= 1'b1;
            st_q.fault_oe <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_hb
            pdfs_half_bridge u_hb (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .pwm_i(g == 0 ? pwm_a_i : pwm_b_i),
                .enable_i(st_q.bridge_en),
                .hs_gate_low_i(hs_gate_low_i[g]),
                .ls_gate_low_i(ls_gate_low_i[g]),
                .hs_on_o(hs_w[g]),
                .ls_on_o(ls_w[g])
            );
        end
    endgenerate
    // final gate stage: registered and cut immediately by the enable
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hs_q <= 2'h0;
            ls_q <= 2'h0;
        end else begin
            hs_q <= st_d.bridge_en ? hs_w : 2'h0;
            ls_q <= st_d.bridge_en ? ls_w : 2'h0;
        end
    end
    assign hs_on_o = hs_q;
    assign ls_on_o = ls_q;
    assign buck_hs_on_o = st_q.buck_hs;
    assign buck_sw_en_o = st_q.buck_en;
    assign buck_sel_o = st_q.buck_sel;
    assign pump_en_o = st_q.pump;
    assign controller_en_o = st_q.ctrl;
    assign slew_sel_o = st_q.slew;
    assign overcurrent_hi_o = st_q.oc_hi;
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe_o = st_q.fault_oe;
    a_pump_sleep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !sleep_reset_n_i |=> !pump_en_o) else $error("pump on in sleep");
    a_buck_limit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        buck_current_limit_i |=> !buck_hs_on_o) else $error("buck hs on over limit");
    a_buck_uv: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        buck_feedback_low_i |=> !buck_sw_en_o && !fault_out_n_oe_o) else $error("buck uv");
    a_ocp_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        st_q.ocp_latch && sleep_reset_n_i && st_q.rst_prev |=> st_q.ocp_latch)
        else $error("latch dropped without pulse");
    a_latch_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        st_q.ocp_latch |=> hs_on_o == 2'h0 && ls_on_o == 2'h0) else $error("bridge on in latch");
    a_pump_uv: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pump_undervoltage_i |=> !fault_out_n_oe_o && hs_on_o == 2'h0) else $error("pump uv");
    a_thermal_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (thermal_shutdown_fet_i || thermal_shutdown_die_i) |=> !pump_en_o && !buck_sw_en_o)
        else $error("thermal not shut");
    a_supply_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (supply_low_lockout_i || logic_rail_low_i) |=> !controller_en_o && !pump_en_o)
        else $error("supply low not shut");
    a_retry_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(st_q.bk == PDFS_BK_RETRY) |-> (st_q.bk == PDFS_BK_RETRY) [*2])
        else $error("retry too short");
    a_fault_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !sig_fault && st_q.bk == PDFS_BK_RUN && !st_q.ocp_latch && $past(!sig_fault)
        |=> fault_out_n_oe_o || sig_fault || st_q.ocp_latch || st_q.bk != PDFS_BK_RUN)
        else $error("fault held with none active");
    c_ocp_latch: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(st_q.ocp_latch));
    c_latch_clear: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(st_q.ocp_latch));
    c_buck_retry: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(st_q.bk == PDFS_BK_RETRY));
    c_sleep: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(st_q.sleep));
endmodule : pdfs_supervisor
`default_nettype wire

/* core/pdfs_regs.svh */
// Purpose: timing counts and pin encodings for the piezo driver fault supervisor
// Assumes: 20 MHz clock, 50 ns period
// Notes: times in ns, cycle counts other than PDFS_IN_DEG_CYC derived from them
`ifndef PDFS_REGS_SVH
`define PDFS_REGS_SVH
`define PDFS_CLK_PERIOD_NS 50
`define PDFS_BRIDGE_OCP_DEG_NS 600
`define PDFS_BRIDGE_OCP_DEG_CYC ((`PDFS_BRIDGE_OCP_DEG_NS + `PDFS_CLK_PERIOD_NS - 1) / `PDFS_CLK_PERIOD_NS)
`define PDFS_BUCK_OCP_DEG_NS 1000
`define PDFS_BUCK_OCP_DEG_CYC ((`PDFS_BUCK_OCP_DEG_NS + `PDFS_CLK_PERIOD_NS - 1) / `PDFS_CLK_PERIOD_NS)
`define PDFS_BUCK_RETRY_NS 100000
`define PDFS_BUCK_RETRY_CYC (`PDFS_BUCK_RETRY_NS / `PDFS_CLK_PERIOD_NS)
`define PDFS_RST_WINDOW_NS 20000
`define PDFS_RST_WINDOW_CYC (`PDFS_RST_WINDOW_NS / `PDFS_CLK_PERIOD_NS)
`define PDFS_IN_DEG_CYC 3
`define PDFS_BUCK_SEL_LOW 1'b0
`define PDFS_BUCK_SEL_HIGH 1'b1
`endif

/* core/pdfs_pkg.sv */
// Purpose: shared types for the piezo driver fault supervisor
// Assumes: nothing
// Notes: slew codes in pin order slowest to fastest
package pdfs_pkg;
    typedef enum logic [1:0] {
        PDFS_SLEW_25,
        PDFS_SLEW_50,
        PDFS_SLEW_125,
        PDFS_SLEW_200
    } pdfs_slew_e;
    typedef enum logic [1:0] {
        PDFS_BK_RUN,
        PDFS_BK_RETRY
    } pdfs_buck_e;
endpackage : pdfs_pkg

/* core/pdfs_half_bridge.sv */
// Purpose: one half-bridge with input deglitch and gate-confirmed dead time
// Assumes: gate-low feedback inputs are synchronous
// Notes: switch turns on only after opposite gate confirmed off
`timescale 1ns/1ns
`default_nettype none
`include "pdfs_regs.svh"
module pdfs_half_bridge #(
    parameter int DEG_CYC = `PDFS_IN_DEG_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic pwm_i,
    input wire logic enable_i,
    // gate feedback
    input wire logic hs_gate_low_i,
    input wire logic ls_gate_low_i,
    // gate drive
    output logic hs_on_o,
    output logic ls_on_o
);
    typedef struct packed {
        logic pwm;
        logic [3:0] cnt;
        logic hs;
        logic ls;
    } pdfs_hb_s;
    pdfs_hb_s st_q, st_d;
    always_comb begin
        st_d = st_q;
        // filter: input must hold steady before being taken
        if (pwm_i == st_q.pwm) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == 4'(DEG_CYC - 1)) begin
            st_d.pwm = pwm_i;
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + 4'h1;
        end
        st_d.hs = enable_i && st_q.pwm && !st_q.ls && ls_gate_low_i;
        st_d.ls = enable_i && !st_q.pwm && !st_q.hs && hs_gate_low_i;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign hs_on_o = st_q.hs;
    assign ls_on_o = st_q.ls;
    a_no_shoot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(hs_on_o && ls_on_o)) else $error("both switches on");
    a_hs_gate_wait: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(hs_on_o) |-> $past(ls_gate_low_i)) else $error("hs on before ls gate low");
    a_deglitch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $changed(st_q.pwm) |-> $past(pwm_i, 1) == st_q.pwm) else $error("filter took glitch");
endmodule : pdfs_half_bridge
`default_nettype wire

/* sim/pdfs_ctrl_model.sv */
// Purpose: controller-side model driving sleep/reset and reading the fault pin
// Assumes: fault pin has an external pull-up
// Notes: reset pulses are clamped to the window, sleep holds the pin low for the window plus n cycles and leaves it low until wake
`timescale 1ns/1ns
`default_nettype none
module pdfs_ctrl_model #(
    parameter int RST_WINDOW_CYC = 8
) (
    // clock
    input wire logic clk_i,
    // fault pin
    input wire logic fault_out_n_i,
    input wire logic fault_out_n_oe_i,
    output logic fault_level_o,
    // sleep/reset pin
    output logic sleep_reset_n_o
);
    assign fault_level_o = fault_out_n_oe_i ? 1'b1 : fault_out_n_i;
    initial sleep_reset_n_o = 1'b1;
    task automatic pulse(input int n);
        sleep_reset_n_o = 1'b0;
        repeat ((n < RST_WINDOW_CYC) ? n : RST_WINDOW_CYC) @(posedge clk_i);
        #5;
        sleep_reset_n_o = 1'b1;
    endtask : pulse
    task automatic sleep(input int n);
        sleep_reset_n_o = 1'b0;
        repeat (RST_WINDOW_CYC + n) @(posedge clk_i);
        #5;
    endtask : sleep
    task automatic wake();
        sleep_reset_n_o = 1'b1;
    endtask : wake
endmodule : pdfs_ctrl_model
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench for the fault supervisor
// Assumes: gate feedback follows gate drive at once unless held stuck
// Notes: long counts shortened through parameters
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pdfs_pkg::*;
    localparam int BK_DEG = 4;
    localparam int BK_RETRY = 20;
    localparam int BR_DEG = 12;
    localparam int RST_WIN = 8;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic pwm_a_i = 1'b0, pwm_b_i = 1'b0, buck_level_pin_i = 1'b0, overcurrent_level_pin_i = 1'b0;
    logic supply_low_lockout_i = 1'b0, logic_rail_low_i = 1'b0, pump_undervoltage_i = 1'b0;
    logic buck_feedback_low_i = 1'b0, buck_feedback_below_ref_i = 1'b0;
    logic buck_current_limit_i = 1'b0, buck_current_ocp_i = 1'b0;
    logic bridge_current_high_lo_i = 1'b0, bridge_current_high_hi_i = 1'b0;
    logic thermal_shutdown_fet_i = 1'b0, thermal_shutdown_die_i = 1'b0;
    logic [1:0] edge_speed_pin_i = 2'h0, stuck = 2'h0;
    logic [1:0] hs_gate_low_i, ls_gate_low_i, hs_on_o, ls_on_o, slew_sel_o;
    logic buck_hs_on_o, buck_sw_en_o, buck_sel_o, pump_en_o, controller_en_o, overcurrent_hi_o;
    logic fault_out_n_o, fault_out_n_oe_o, fault_lvl, sleep_reset_n_i;
    logic [3:0] f;
    int bad_count = 0, tests_run = 0, seed = 32'hC78B5A56;
    // gate feedback, low-side report can be held stuck on
    assign hs_gate_low_i = ~hs_on_o;
    assign ls_gate_low_i = ~ls_on_o & ~stuck;
    pdfs_supervisor #(.BUCK_DEG_CYC(BK_DEG), .BRIDGE_DEG_CYC(BR_DEG), .BUCK_RETRY_CYC(BK_RETRY),
        .RST_WINDOW_CYC(RST_WIN)) pdfs_supervisor_i (.*);
    pdfs_ctrl_model #(.RST_WINDOW_CYC(RST_WIN)) pdfs_ctrl_model_i (.clk_i(clk_i),
        .fault_out_n_i(fault_out_n_o), .fault_out_n_oe_i(fault_out_n_oe_o),
        .fault_level_o(fault_lvl), .sleep_reset_n_o(sleep_reset_n_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask : cyc
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: got %b expected %b", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic setf(input logic [3:0] v);
        f = v;
        {thermal_shutdown_die_i, thermal_shutdown_fet_i, buck_feedback_low_i, pump_undervoltage_i} = v;
        cyc(3);
    endtask : setf
    function automatic logic [1:0] fault_exp(input logic [3:0] v);
        return {1'b0, ~|v};
    endfunction : fault_exp
    function automatic logic [1:0] leg_exp(input logic pwm);
        return {pwm, ~pwm};
    endfunction : leg_exp
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end
    initial begin
        cyc(6);
        reset_n_i = 1'b1;
        cyc(3);
        chk({1'b0, fault_lvl}, 2'b01);
        for (int i = 0; i < 8; i++) begin
            edge_speed_pin_i = 2'(i);
            buck_level_pin_i = 1'($random(seed));
            overcurrent_level_pin_i = 1'($random(seed));
            buck_feedback_below_ref_i = 1'($random(seed));
            buck_current_limit_i = 1'($random(seed));
            pwm_a_i = 1'($random(seed));
            pwm_b_i = 1'($random(seed));
            cyc(8);
            chk(slew_sel_o, edge_speed_pin_i);
            chk({buck_sel_o, overcurrent_hi_o}, {buck_level_pin_i, overcurrent_level_pin_i});
            chk({1'b0, buck_hs_on_o}, {1'b0, buck_feedback_below_ref_i & ~buck_current_limit_i});
            chk({hs_on_o[0], ls_on_o[0]}, leg_exp(pwm_a_i));
            chk({hs_on_o[1], ls_on_o[1]}, leg_exp(pwm_b_i));
        end
        pwm_a_i = 1'b1;
        cyc(8);
        pwm_a_i = 1'b0;
        cyc(2);
        pwm_a_i = 1'b1;
        repeat (6) begin
            cyc(1);
            chk({hs_on_o[0], ls_on_o[0]}, 2'b10);
        end
        pwm_a_i = 1'b0;
        cyc(8);
        stuck = 2'b01;
        pwm_a_i = 1'b1;
        cyc(8);
        chk({1'b0, hs_on_o[0]}, 2'b00);
        stuck = 2'b00;
        cyc(4);
        chk({hs_on_o[0], ls_on_o[0]}, 2'b10);
        pwm_a_i = 1'b0;
        pwm_b_i = 1'b0;
        cyc(8);
        for (int k = 0; k < 4; k++) begin
            setf(4'h1 << k);
            chk({1'b0, fault_lvl}, fault_exp(f));
            chk(hs_on_o | ls_on_o, (k == 1) ? 2'b11 : 2'b00);
            chk({buck_sw_en_o, pump_en_o | (k == 0)}, {1'(k == 0), 1'(k < 2)});
            setf(4'h0);
            cyc(8);
            chk({buck_sw_en_o, fault_lvl}, 2'b11);
            chk(hs_on_o | ls_on_o, 2'b11);
        end
        setf(4'h9);
        setf(4'h8);
        chk({1'b0, fault_lvl}, fault_exp(f));
        setf(4'h0);
        chk({1'b0, fault_lvl}, fault_exp(f));
        for (int k = 0; k < 2; k++) begin
            {logic_rail_low_i, supply_low_lockout_i} = 2'(k + 1);
            cyc(3);
            chk({controller_en_o, pump_en_o}, 2'b00);
            chk(hs_on_o | ls_on_o, 2'b00);
            {logic_rail_low_i, supply_low_lockout_i} = 2'h0;
            cyc(10);
            chk({controller_en_o, pump_en_o}, 2'b11);
        end
        overcurrent_level_pin_i = 1'b1;
        bridge_current_high_lo_i = 1'b1;
        cyc(BR_DEG + 4);
        bridge_current_high_lo_i = 1'b0;
        cyc(2);
        chk({1'b0, fault_lvl}, 2'b01);
        bridge_current_high_hi_i = 1'b1;
        cyc(BR_DEG - 2);
        bridge_current_high_hi_i = 1'b0;
        cyc(3);
        chk({1'b0, fault_lvl}, 2'b01);
        bridge_current_high_hi_i = 1'b1;
        cyc(BR_DEG + 3);
        bridge_current_high_hi_i = 1'b0;
        cyc(3);
        chk({1'b0, fault_lvl}, 2'b00);
        chk(hs_on_o | ls_on_o, 2'b00);
        pdfs_ctrl_model_i.sleep(4);
        chk({1'b0, pump_en_o}, 2'b00);
        pdfs_ctrl_model_i.wake();
        cyc(8);
        chk({1'b0, fault_lvl}, 2'b00);
        pdfs_ctrl_model_i.pulse(5);
        cyc(3);
        chk({1'b0, fault_lvl}, 2'b01);
        buck_current_ocp_i = 1'b1;
        cyc(BK_DEG - 1);
        buck_current_ocp_i = 1'b0;
        cyc(2);
        chk({buck_sw_en_o, fault_lvl}, 2'b11);
        buck_current_ocp_i = 1'b1;
        cyc(BK_DEG + 2);
        buck_current_ocp_i = 1'b0;
        cyc(1);
        chk({buck_sw_en_o, fault_lvl}, 2'b00);
        cyc(BK_RETRY - 8);
        chk({buck_sw_en_o, fault_lvl}, 2'b00);
        cyc(10);
        chk({buck_sw_en_o, fault_lvl}, 2'b11);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
